// ==== design/drive_seq_consts.svh ====
// Constants for the drive sequencer, fault logic and register map
// Contract
// - speed flag only above about 1000 rpm
// - speed flag gates head load and retract
// - turning status low while spindle rotates
// - pack locks closed while spindle rotates
// - cartridge sector pulses pass undivided
// - fixed disk 40 holes divided by two
// - write channel summary is a fault input
// - illegal input combinations raise faults
// - damaging fault disables servo, retracts heads
// - damaging fault cleared only by start/stop
// - fault clear clears nondamaging faults
// - multi head or read with write nondamaging
// - damaging power fault trips main breaker (code trips it on over temperature only)
// - start needs breakers, cover, arms
// - run lamp lit while motor energized
// - run lamp lit until stopped and released
// - first seek automatic, about 65 seconds
// - damaging fault in first seek stops drive
// - ready lamp only at speed, heads loaded
// - active lamp while seeking, reading, writing
// - fault lamp for all but power loss
// - power drop retracts, stops, then restarts
// - write protect toggles per surface with lamp
// - restore command clears fault lamp (code clears nondamaging faults only; a damaging fault keeps it lit)
`ifndef DRIVE_SEQ_CONSTS_SVH
`define DRIVE_SEQ_CONSTS_SVH
`define OFS_CFG 8'h00
`define OFS_STAT 8'h04
`define CFG_RST 2'h2
`define DEB_RST 11'h07c
`define CLK_HZ 10000000
`define FIRST_SEEK_S 65
`define FIRST_SEEK_CYC (`FIRST_SEEK_S * `CLK_HZ)
`define SPEED_RPM 1000
`define SPEED_CYC (60 * `CLK_HZ / `SPEED_RPM)
`define ROT_TIMEOUT_MS 1000
`define ROT_CYC (`ROT_TIMEOUT_MS * (`CLK_HZ / 1000))
`define DEB_MS 5
`define DEB_CYC (`DEB_MS * (`CLK_HZ / 1000))
`define RETRACT_US 400
`define RETRACT_CYC ((`RETRACT_US * (`CLK_HZ / 1000) + 999) / 1000)
`define RELEASE_MS 200
`define RELEASE_CYC (`RELEASE_MS * (`CLK_HZ / 1000))
`define IN_SS 10
`define IN_FC 9
`define IN_WPC 8
`define IN_WPF 7
`define IN_BRK 6
`define IN_COV 5
`define IN_ARM 4
`define IN_REG 3
`define IN_ACOK 2
`define IN_OVT 1
`define IN_WCF 0
`endif

// ==== design/drive_seq_pkg.sv ====
// Types for the drive sequencer
package drive_seq_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SEEK = 6'h02,
    S_RDY  = 6'h04,
    S_RETR = 6'h08,
    S_STOP = 6'h10,
    S_REL  = 6'h20
  } seq_st_t;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axil_rsp_t;
  typedef struct packed {
    logic start_stop; logic fault_clear; logic wp_cart_btn; logic wp_fixed_btn;
    logic breakers_closed; logic cover_in_place; logic arms_positioned;
    logic regulators_ok; logic ac_power_ok; logic over_temp;
    logic write_channel_fault_summary;
  } panel_in_t;
  typedef struct packed {
    logic [3:0] head_select; logic read_req; logic write_req;
    logic seek_busy; logic restore_cmd;
  } ctrl_in_t;
  typedef struct packed {
    logic spindle_motor_on; logic servo_enable; logic heads_load;
    logic emergency_retract; logic pack_lock_release; logic breaker_trip;
    logic spindle_turning_n; logic cart_sector_out; logic fixed_sector_out;
  } drive_out_t;
  typedef struct packed {
    logic run_lamp; logic ready_lamp; logic active_lamp; logic fault_lamp;
    logic removable_write_inhibit; logic fixed_write_inhibit;
  } lamp_t;
  typedef struct packed {
    axil_rsp_t rsp; logic aw_got; logic [7:0] awaddr; logic w_got;
    logic [1:0] wd; logic wst; logic [1:0] cfg;
    logic [10:0] s1; logic [10:0] s2; logic [10:0] deb; logic [10:0] deb_d;
    logic [10:0][15:0] dcnt;
    logic [2:0] p1; logic [2:0] p2; logic [2:0] p3;
    logic [23:0] ip; logic seen; logic spd; logic [1:0] div;
    seq_st_t st; logic [31:0] tmr; logic dmg; logic nd; logic restart;
    drive_out_t o; lamp_t l;
  } seq_state_t;
endpackage : drive_seq_pkg

// ==== design/drive_seq_ctrl.sv ====
// Drive start/stop sequencer, fault logic, sector division and register slave
`include "drive_seq_consts.svh"
module drive_seq_ctrl #(
  parameter int FIRST_SEEK_CYC = `FIRST_SEEK_CYC,
  parameter int SPEED_CYC      = `SPEED_CYC,
  parameter int ROT_CYC        = `ROT_CYC,
  parameter int DEB_CYC        = `DEB_CYC,
  parameter int RELEASE_CYC    = `RELEASE_CYC
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Register bus
  input  wire drive_seq_pkg::axil_req_t  axi_req,
  output drive_seq_pkg::axil_rsp_t       axi_rsp,
  // Operator panel and sensors
  input  wire drive_seq_pkg::panel_in_t  panel,
  input  wire logic                      cart_sector_pulse,
  input  wire logic                      fixed_sector_pulse,
  input  wire logic                      index_pulse,
  // Disk controller
  input  wire drive_seq_pkg::ctrl_in_t   ctrl,
  // Drive and lamp outputs
  output drive_seq_pkg::drive_out_t      drive,
  output drive_seq_pkg::lamp_t           lamps
);
  import drive_seq_pkg::*;

  localparam int RETRACT_CYC = `RETRACT_CYC;

  seq_state_t  r;
  seq_state_t  n;
  logic [10:0] press;
  logic [2:0]  edge_p;
  logic        running;
  logic        ok_start;
  logic        dmg_cause;
  logic        nd_cause;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;

  assign press   = r.deb & ~r.deb_d;
  assign edge_p  = r.p2 & ~r.p3;
  assign running = (r.st == S_SEEK) || (r.st == S_RDY);
  assign ok_start = r.deb[`IN_BRK] & r.deb[`IN_COV] & r.deb[`IN_ARM];

  // Damaging: supply, overheating, interlock opened or speed lost under loaded heads
  assign dmg_cause = ~r.deb[`IN_REG] | r.deb[`IN_OVT]
                   | (running & ~ok_start)
                   | (r.o.heads_load & (r.ip >= 24'(SPEED_CYC)));
  // Nondamaging: several heads, read with write, write channel summary
  assign nd_cause = ((ctrl.head_select & (ctrl.head_select - 4'h1)) != 4'h0)
                  | (ctrl.read_req & ctrl.write_req)
                  | r.deb[`IN_WCF];

  assign aw_hs = axi_req.awvalid & r.rsp.awready;
  assign w_hs  = axi_req.wvalid & r.rsp.wready;
  assign ar_hs = axi_req.arvalid & r.rsp.arready;

  assign axi_rsp = r.rsp;
  assign drive   = r.o;
  assign lamps   = r.l;

  always_comb
  begin
    n = r;

    // Two-stage synchroniser then a stable-time debounce per input
    n.s1 = panel;
    n.s2 = r.s1;
    n.deb_d = r.deb;
    for (int i = 0; i < 11; i++)
    begin
      if (r.s2[i] == r.deb[i])
        n.dcnt[i] = 16'h0;
      else if (r.dcnt[i] == 16'(DEB_CYC - 1))
      begin
        n.deb[i] = r.s2[i];
        n.dcnt[i] = 16'h0;
      end
      else
        n.dcnt[i] = r.dcnt[i] + 16'h1;
    end

    // Sector and index pulses: synchronise, then rising edge
    n.p1 = {index_pulse, fixed_sector_pulse, cart_sector_pulse};
    n.p2 = r.p1;
    n.p3 = r.p2;

    // Index period gives speed and rotation
    if (edge_p[2])
    begin
      n.ip = 24'h0;
      n.seen = 1'b1;
      n.spd = r.seen && (r.ip < 24'(SPEED_CYC));
    end
    else if (r.ip == 24'(ROT_CYC))
      n.seen = 1'b0;
    else
      n.ip = r.ip + 24'h1;
    if (!edge_p[2] && r.ip >= 24'(SPEED_CYC))
      n.spd = 1'b0;

    // Sector division per surface; cfg bit set means divide by two
    for (int i = 0; i < 2; i++)
      if (edge_p[i])
        n.div[i] = ~r.div[i];
    n.o.cart_sector_out  = edge_p[0] & (~r.cfg[0] | r.div[0]);
    n.o.fixed_sector_out = edge_p[1] & (~r.cfg[1] | r.div[1]);

    // Write protect toggles
    if (press[`IN_WPC])
      n.l.removable_write_inhibit = ~r.l.removable_write_inhibit;
    if (press[`IN_WPF])
      n.l.fixed_write_inhibit = ~r.l.fixed_write_inhibit;

    // Fault latches; a new cause wins over a clear
    if (press[`IN_FC] || ctrl.restore_cmd)
      n.nd = 1'b0;
    if (nd_cause)
      n.nd = 1'b1;
    if (press[`IN_SS] && !dmg_cause)
      n.dmg = 1'b0;
    if (dmg_cause)
      n.dmg = 1'b1;

    // Sequence
    unique case (r.st)
      S_IDLE:
      begin
        n.tmr = 32'h0;
        if (!r.dmg && ok_start && r.deb[`IN_ACOK] && (press[`IN_SS] || r.restart))
        begin
          n.st = S_SEEK;
          n.restart = 1'b0;
        end
      end
      S_SEEK, S_RDY:
      begin
        if (r.dmg)
        begin
          n.st = S_RETR;
          n.tmr = 32'h0;
        end
        else if (!r.deb[`IN_ACOK])
        begin
          n.st = S_RETR;
          n.tmr = 32'h0;
          n.restart = 1'b1;
        end
        else if (press[`IN_SS])
        begin
          n.st = S_STOP;
          n.tmr = 32'h0;
        end
        else if (r.st == S_SEEK)
        begin
          if (r.tmr != 32'(FIRST_SEEK_CYC - 1))
            n.tmr = r.tmr + 32'h1;
          else if (r.spd)
            n.st = S_RDY;
        end
      end
      S_RETR:
      begin
        n.tmr = r.tmr + 32'h1;
        if (r.tmr == 32'(RETRACT_CYC - 1))
        begin
          n.st = S_STOP;
          n.tmr = 32'h0;
        end
      end
      S_STOP:
      begin
        if (!r.seen)
          n.st = S_REL;
      end
      S_REL:
      begin
        n.tmr = r.tmr + 32'h1;
        if (r.tmr == 32'(RELEASE_CYC - 1))
          n.st = S_IDLE;
      end
      default:
        n.st = S_IDLE;
    endcase

    // Outputs follow next state
    n.o.spindle_motor_on = (n.st == S_SEEK) || (n.st == S_RDY);
    n.o.servo_enable = n.o.spindle_motor_on && !n.dmg;
    n.o.heads_load = !n.dmg && n.spd
                     && ((n.st == S_SEEK) || (n.st == S_RDY));
    n.o.emergency_retract = (n.st == S_RETR);
    n.o.pack_lock_release = ((n.st == S_REL) || (n.st == S_IDLE)) && !n.seen;
    n.o.breaker_trip = n.dmg && r.deb[`IN_OVT];
    n.o.spindle_turning_n = !n.seen;
    n.l.run_lamp = (n.st != S_IDLE);
    n.l.ready_lamp = (n.st == S_RDY) && n.o.heads_load && !n.nd;
    n.l.active_lamp = n.o.spindle_motor_on
                      && (ctrl.seek_busy | ctrl.read_req | ctrl.write_req);
    n.l.fault_lamp = n.dmg || n.nd;

    // Register write path
    if (aw_hs)
    begin
      n.aw_got = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (w_hs)
    begin
      n.w_got = 1'b1;
      n.wd = axi_req.wdata[1:0];
      n.wst = axi_req.wstrb[0];
    end
    if (r.rsp.bvalid && axi_req.bready)
      n.rsp.bvalid = 1'b0;
    if (r.aw_got && r.w_got && !r.rsp.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = 2'h0;
      if (r.awaddr == `OFS_CFG)
      begin
        if (r.wst)
          n.cfg = r.wd;
      end
      else if (r.awaddr != `OFS_STAT)
        n.rsp.bresp = 2'h2;
    end
    n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
    n.rsp.wready = !n.w_got && !n.rsp.bvalid;

    // Register read path
    if (r.rsp.rvalid && axi_req.rready)
      n.rsp.rvalid = 1'b0;
    if (ar_hs)
    begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = 2'h0;
      if (axi_req.araddr == `OFS_CFG)
        n.rsp.rdata = {30'h0, r.cfg};
      else if (axi_req.araddr == `OFS_STAT)
        n.rsp.rdata = {13'h0, r.st, r.dmg, r.nd, r.restart, r.spd, r.seen, r.l, r.cfg};
      else
      begin
        n.rsp.rdata = 32'h0;
        n.rsp.rresp = 2'h2;
      end
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.st <= S_IDLE;
      r.cfg <= `CFG_RST;
      r.o.spindle_turning_n <= 1'b1;
      // Panel starts at rest so power-up raises no false fault or press
      r.s1 <= `DEB_RST;
      r.s2 <= `DEB_RST;
      r.deb <= `DEB_RST;
      r.deb_d <= `DEB_RST;
    end
    else
      r <= n;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_speed;
    r.spd |-> r.ip <= 24'(SPEED_CYC);
  endproperty
  a_speed: assert property (p_speed) else $error("speed flag without fast index");

  property p_load;
    r.o.heads_load |-> r.spd && !r.dmg;
  endproperty
  a_load: assert property (p_load) else $error("heads loaded below speed");

  property p_turn;
    r.o.spindle_turning_n != r.seen;
  endproperty
  a_turn: assert property (p_turn) else $error("turning status wrong");

  property p_lock;
    r.o.pack_lock_release |-> r.o.spindle_turning_n;
  endproperty
  a_lock: assert property (p_lock) else $error("locks open while turning");

  property p_div;
    r.o.fixed_sector_out && r.cfg[1] |-> !r.div[1] && $past(r.div[1]);
  endproperty
  a_div: assert property (p_div) else $error("fixed sector not halved");

  property p_retr;
    r.dmg && running |=> r.st == S_RETR && !r.o.servo_enable;
  endproperty
  a_retr: assert property (p_retr) else $error("no retract on damaging fault");

  property p_dmgfc;
    r.dmg && press[`IN_FC] && !press[`IN_SS] |=> r.dmg && r.l.fault_lamp;
  endproperty
  a_dmgfc: assert property (p_dmgfc) else $error("fault clear cleared damaging fault");

  property p_ndfc;
    r.nd && press[`IN_FC] && !nd_cause |=> !r.nd;
  endproperty
  a_ndfc: assert property (p_ndfc) else $error("fault clear ignored");

  property p_run;
    r.o.spindle_motor_on |-> r.l.run_lamp;
  endproperty
  a_run: assert property (p_run) else $error("run lamp off while motor on");

  property p_ready;
    r.l.ready_lamp |-> !r.l.fault_lamp && r.o.heads_load && r.st == S_RDY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready lamp wrongly lit");

  property p_cart;
    edge_p[0] && !r.cfg[0] |=> r.o.cart_sector_out;
  endproperty
  a_cart: assert property (p_cart) else $error("cartridge sector pulse dropped");

  property p_start;
    r.st == S_IDLE && press[`IN_SS] && !r.dmg && ok_start && r.deb[`IN_ACOK]
      |=> r.o.spindle_motor_on && r.l.run_lamp;
  endproperty
  a_start: assert property (p_start) else $error("start press did not start");

  property p_wp;
    press[`IN_WPC] |=> r.l.removable_write_inhibit != $past(r.l.removable_write_inhibit);
  endproperty
  a_wp: assert property (p_wp) else $error("write protect did not toggle");

  property p_rstr;
    r.nd && ctrl.restore_cmd && !nd_cause |=> !r.nd;
  endproperty
  a_rstr: assert property (p_rstr) else $error("restore kept nondamaging fault");

endmodule : drive_seq_ctrl

// ==== verification/drive_sensor_model.sv ====
// Spindle and sector ring model that answers the motor drive
module drive_sensor_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Motor drive from the device
  input  wire logic motor_on,
  // Sensor pulses to the device
  output logic      index_pulse,
  output logic      cart_sector_pulse,
  output logic      fixed_sector_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ph;
  logic [7:0] coast;
  // Spindle coasts 100 cycles after the motor is cut, then stands still
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph    <= 6'h00;
      coast <= 8'h00;
    end
    else
    begin
      coast <= motor_on ? 8'h64 : (coast != 8'h00 ? coast - 8'h01 : 8'h00);
      ph    <= (ph == 6'h27) ? 6'h00 : ph + 6'h01;
    end
  end
  // Scaled ring: 40 cycle turn, well above speed threshold
  assign index_pulse        = (coast != 8'h00) && (ph == 6'h00);
  assign cart_sector_pulse  = (coast != 8'h00) && (ph[1:0] == 2'h1);
  assign fixed_sector_pulse = (coast != 8'h00) && ph[0];
endmodule : drive_sensor_model

// ==== verification/disk_drive_sequence_fault_control_tb.sv ====
// Self-checking bench for the drive sequencer and fault logic
`include "drive_seq_consts.svh"
module disk_drive_sequence_fault_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import drive_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  axil_req_t   req = '0;
  axil_rsp_t   rsp;
  panel_in_t   panel = 11'h07c;
  ctrl_in_t    ctrl = '0;
  drive_out_t  drive;
  lamp_t       lamps;
  logic        idx, cin, fin;
  logic [14:0] obs;
  logic [1:0]  pv = 2'h0;
  logic [31:0] d, e;
  logic [1:0]  r;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          i;
  int          n_ci = 0, n_fi = 0, n_co = 0, n_fo = 0;
  drive_seq_ctrl #(.FIRST_SEEK_CYC(2000), .SPEED_CYC(50), .ROT_CYC(200), .DEB_CYC(4),
    .RELEASE_CYC(20)) u_dut (.clk(clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
    .panel(panel), .cart_sector_pulse(cin), .fixed_sector_pulse(fin), .index_pulse(idx),
    .ctrl(ctrl), .drive(drive), .lamps(lamps));
  drive_sensor_model u_model (.clk(clk), .rst_b(rst_b), .motor_on(drive.spindle_motor_on),
    .index_pulse(idx), .cart_sector_pulse(cin), .fixed_sector_pulse(fin));
  assign obs = {drive, lamps};
  always #50 clk = ~clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask : chk
  // Status word as laid out in the register map
  function automatic logic [31:0] stat_word(input logic [5:0] st, input logic [4:0] flg,
    input logic [5:0] lmp, input logic [1:0] cf);
    return {13'h0, st, flg, lmp, cf};
  endfunction : stat_word
  // Sector pulses expected from the input count and the divide setting
  function automatic int exp_sectors(input int pulses, input logic halve);
    return halve ? pulses / 2 : pulses;
  endfunction : exp_sectors
  // Counts sensor edges and device sector pulses; cuts a hang short
  always @(posedge clk)
  begin
    cyc  <= cyc + 1;
    pv   <= {cin, fin};
    n_ci <= n_ci + int'(cin && !pv[1]);
    n_fi <= n_fi + int'(fin && !pv[0]);
    n_co <= n_co + int'(drive.cart_sector_out === 1'b1);
    n_fo <= n_fo + int'(drive.fixed_sector_out === 1'b1);
    if (cyc == 60000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic wait_bit(input string n, input int k, input logic v, input int lim);
    for (int j = 0; j < lim && obs[k] !== v; j++) @(posedge clk);
    chk(n, v, obs[k]);
  endtask : wait_bit
  task automatic press(input int k);
    @(posedge clk);
    panel[k] <= 1'b1;
    repeat (12) @(posedge clk);
    panel[k] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] b);
    logic aw, w;
    @(posedge clk);
    aw = 1'b0;
    w = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk);
      aw = aw || (rsp.awready === 1'b1);
      w  = w || (rsp.wready === 1'b1);
      req.awvalid <= !aw;
      req.wvalid  <= !w;
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    b = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
    logic ar;
    @(posedge clk);
    ar = 1'b0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      ar = ar || (rsp.arready === 1'b1);
      req.arvalid <= !ar;
    end
    while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    b = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  initial
  begin
    d = $urandom(32'h9610);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    ctrl.head_select <= 4'h1;
    repeat (10) @(posedge clk);
    chk("lock idle", 1'b1, drive.pack_lock_release);
    chk("turn idle", 1'b1, drive.spindle_turning_n);
    rd(8'h00, d, r);
    chk("cfg rst", 32'h2, d);
    rd(8'h04, d, r);
    chk("stat idle", stat_word(6'h01, 5'h00, 6'h00, 2'h2), d);
    wr(8'h04, $urandom, r);
    chk("stat wr", 2'h0, r);
    rd(8'h40, d, r);
    chk("rd err", 2'h2, r);
    wr(8'h40, $urandom, r);
    chk("wr err", 2'h2, r);
    e = $urandom;
    wr(8'h00, e, r);
    rd(8'h00, d, r);
    chk("cfg rw", {30'h0, e[1:0]}, d);
    wr(8'h00, 32'h2, r);
    press(`IN_SS);
    chk("motor", 1'b1, drive.spindle_motor_on);
    chk("run", 1'b1, lamps.run_lamp);
    wait_bit("load", 12, 1'b1, 200);
    chk("turning", 1'b0, drive.spindle_turning_n);
    chk("locked", 1'b0, drive.pack_lock_release);
    wait_bit("ready", 4, 1'b1, 3000);
    rd(8'h04, d, r);
    chk("stat rdy", stat_word(6'h04, 5'h03, 6'h30, 2'h2), d);
    ctrl.seek_busy <= 1'b1;
    wait_bit("active", 3, 1'b1, 10);
    ctrl.seek_busy <= 1'b0;
    press(`IN_WPC);
    chk("wp cart", 1'b1, lamps.removable_write_inhibit);
    press(`IN_WPC);
    chk("wp off", 1'b0, lamps.removable_write_inhibit);
    press(`IN_WPF);
    chk("wp fix", 1'b1, lamps.fixed_write_inhibit);
    i = $urandom % 4;
    ctrl.head_select <= 4'h1 << i | 4'h1 << ((i + 1 + $urandom % 3) % 4);
    wait_bit("heads", 2, 1'b1, 20);
    chk("rdy flt", 1'b0, lamps.ready_lamp);
    ctrl.head_select <= 4'h1;
    press(`IN_FC);
    chk("clear", 1'b0, lamps.fault_lamp);
    ctrl.read_req <= 1'b1;
    ctrl.write_req <= 1'b1;
    wait_bit("rd wr", 2, 1'b1, 20);
    ctrl.read_req <= 1'b0;
    ctrl.write_req <= 1'b0;
    ctrl.restore_cmd <= 1'b1;
    wait_bit("restore", 2, 1'b0, 20);
    ctrl.restore_cmd <= 1'b0;
    panel[`IN_WCF] <= 1'b1;
    wait_bit("wcf", 2, 1'b1, 20);
    panel[`IN_WCF] <= 1'b0;
    press(`IN_FC);
    chk("wcf clr", 1'b0, lamps.fault_lamp);
    panel[`IN_OVT] <= 1'b1;
    wait_bit("retract", 11, 1'b1, 20);
    chk("servo", 1'b0, drive.servo_enable);
    chk("trip", 1'b1, drive.breaker_trip);
    chk("rdy off", 1'b0, lamps.ready_lamp);
    press(`IN_FC);
    chk("dmg kept", 1'b1, lamps.fault_lamp);
    wait_bit("release", 10, 1'b1, 6000);
    chk("run held", 1'b1, lamps.run_lamp);
    chk("stopped", 1'b1, drive.spindle_turning_n);
    wait_bit("run off", 5, 1'b0, 100);
    press(`IN_SS);
    chk("dmg held", 1'b1, lamps.fault_lamp);
    panel[`IN_OVT] <= 1'b0;
    press(`IN_SS);
    chk("dmg clr", 1'b0, lamps.fault_lamp);
    chk("no start", 1'b0, drive.spindle_motor_on);
    press(`IN_SS);
    chk("start", 1'b1, drive.spindle_motor_on);
    wait_bit("load2", 12, 1'b1, 200);
    panel[`IN_ACOK] <= 1'b0;
    wait_bit("ac retr", 11, 1'b1, 20);
    chk("ac lamp", 1'b0, lamps.fault_lamp);
    panel[`IN_ACOK] <= 1'b1;
    wait_bit("auto", 14, 1'b1, 8000);
    press(`IN_SS);
    chk("stop", 1'b0, drive.spindle_motor_on);
    chk("run stp", 1'b1, lamps.run_lamp);
    wait_bit("unlock", 10, 1'b1, 1000);
    wait_bit("run end", 5, 1'b0, 100);
    chk("cart div", exp_sectors(n_ci, 1'b0), n_co);
    chk("fix div", exp_sectors(n_fi, 1'b1), n_fo);
    press(`IN_SS);
    wait_bit("load3", 12, 1'b1, 200);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst motor", 1'b0, drive.spindle_motor_on);
    chk("rst run", 1'b0, lamps.run_lamp);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst lock", 1'b1, drive.pack_lock_release);
    chk("rst turn", 1'b1, drive.spindle_turning_n);
    summarize();
  end
endmodule : disk_drive_sequence_fault_control_tb
